//--- rtl/rssl_pkg.sv
// Package of constants and types for the recorder signal source logic
package rssl_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Source counts
    localparam int NUM_CHANNELS = 24;
    localparam int ALARMS_PER_CH = 4;
    localparam int NUM_ALARMS = NUM_CHANNELS * ALARMS_PER_CH;
    localparam int NUM_GROUPS = 12;
    localparam int GROUP_SEL_W = 4;
    localparam int NUM_RT_ALARMS = 4;
    localparam int TOT_PER_CH = 2;
    localparam int NUM_TOTALIZERS = NUM_CHANNELS * TOT_PER_CH;
    localparam int NUM_LOGIC_EQ = 24;
    localparam int NUM_HYBRID_DI = 10;
    localparam int NUM_HYBRID_MOD = 2;
    localparam int HYBRID_DI_PER_MOD = 5;

    ////////////////////////////////////////////////////////////////////////
    // Timing
    localparam int CLK_FREQ_HZ = 40_000_000;
    localparam int MS_PER_S = 1000;
    localparam int MS_TICK_CYCLES = CLK_FREQ_HZ / MS_PER_S;
    localparam int MS_CNT_W = 16;
    localparam int WRAP_PULSE_TIME_S = 1;
    localparam int INTER_PULSE_TIME_S = 1;
    localparam int COUNT_PULSE_TIME_MS = 100;
    localparam int PULSE_CNT_W = 10;
    localparam logic [PULSE_CNT_W-1:0] WRAP_PULSE_TICKS =
        PULSE_CNT_W'(WRAP_PULSE_TIME_S * MS_PER_S);
    localparam logic [PULSE_CNT_W-1:0] INTER_PULSE_TICKS =
        PULSE_CNT_W'(INTER_PULSE_TIME_S * MS_PER_S);
    localparam logic [PULSE_CNT_W-1:0] COUNT_PULSE_TICKS =
        PULSE_CNT_W'(COUNT_PULSE_TIME_MS);
    localparam logic [PULSE_CNT_W-1:0] PULSE_ZERO = 10'h000;
    localparam logic [PULSE_CNT_W-1:0] PULSE_ONE = 10'h001;

    ////////////////////////////////////////////////////////////////////////
    // Register bus
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam logic [ADDR_W-1:0] IRQ_STATUS_OFS = 8'h00;
    localparam logic [ADDR_W-1:0] IRQ_ENABLE_OFS = 8'h04;
    localparam logic [ADDR_W-1:0] IRQ_CLEAR_OFS = 8'h08;
    localparam logic [ADDR_W-1:0] SUMMARY_OFS = 8'h0C;

    // Interrupt field layout
    localparam int IRQ_W = 5;
    localparam int IRQ_NEW_ALARM_BIT = 0;
    localparam int IRQ_WRAP_BIT = 1;
    localparam int IRQ_INTER_BIT = 2;
    localparam int IRQ_MEDIA_BIT = 3;
    localparam int IRQ_PF_ABORT_BIT = 4;
    localparam logic [IRQ_W-1:0] IRQ_RESET_VAL = 5'h00;
    localparam logic [DATA_W-1:0] DATA_ZERO = 32'h00000000;

    // Power-up abort sequencer
    typedef enum logic [1:0] {
        PU_WAIT,
        PU_PULSE,
        PU_DONE
    } rssl_pu_state_type;

endpackage : rssl_pkg

//--- rtl/rssl_top.sv
// Recorder internal digital signal sources with interrupt register port
`timescale 1ns/1ps

module rssl_top #(
    parameter int MS_TICK_CYCLES_P = rssl_pkg::MS_TICK_CYCLES
) (
    // Clock and reset
    input wire logic sys_clk_in,
    input wire logic reset_n_in,
    // Register port
    input wire logic [rssl_pkg::ADDR_W-1:0] reg_addr_in,
    input wire logic [rssl_pkg::DATA_W-1:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [rssl_pkg::DATA_W-1:0] reg_rdata_out,
    output logic irq_out,
    // Alarm evaluators
    input wire logic [rssl_pkg::NUM_ALARMS-1:0] alarm_enable_in,
    input wire logic [rssl_pkg::NUM_ALARMS-1:0] alarm_active_in,
    input wire logic [rssl_pkg::NUM_ALARMS-1:0] alarm_unack_in,
    input wire logic [rssl_pkg::NUM_ALARMS-1:0] alarm_ack_type_in,
    input wire logic [rssl_pkg::NUM_ALARMS*rssl_pkg::GROUP_SEL_W-1:0]
        alarm_group_sel_in,
    input wire logic [rssl_pkg::NUM_RT_ALARMS-1:0] rt_alarm_enable_in,
    input wire logic [rssl_pkg::NUM_RT_ALARMS-1:0] rt_alarm_active_in,
    // Totalizers
    input wire logic tot_option_in,
    input wire logic [rssl_pkg::NUM_TOTALIZERS-1:0] tot_enable_in,
    input wire logic [rssl_pkg::NUM_TOTALIZERS-1:0] tot_running_in,
    input wire logic [rssl_pkg::NUM_TOTALIZERS-1:0] tot_wrap_auto_in,
    input wire logic [rssl_pkg::NUM_TOTALIZERS-1:0] tot_wrap_reached_in,
    input wire logic [rssl_pkg::NUM_TOTALIZERS-1:0] tot_reset_in,
    input wire logic [rssl_pkg::NUM_TOTALIZERS-1:0] tot_inter_reached_in,
    input wire logic [rssl_pkg::NUM_TOTALIZERS-1:0] tot_whole_count_in,
    // Math and logic
    input wire logic math_option_in,
    input wire logic [rssl_pkg::NUM_LOGIC_EQ-1:0] logic_eq_enable_in,
    input wire logic [rssl_pkg::NUM_LOGIC_EQ-1:0] logic_eq_result_in,
    // Batch, hybrid inputs, archive
    input wire logic batch_running_in,
    input wire logic [rssl_pkg::NUM_HYBRID_MOD-1:0] hybrid_fitted_in,
    input wire logic [rssl_pkg::NUM_HYBRID_DI-1:0] hybrid_di_in,
    input wire logic media_detect_in,
    input wire logic archive_active_in,
    // Alarm sources
    output logic [rssl_pkg::NUM_ALARMS-1:0] alarm_state_out,
    output logic [rssl_pkg::NUM_ALARMS-1:0] alarm_ack_out,
    output logic [rssl_pkg::NUM_GROUPS-1:0] alarm_group_out,
    output logic any_alarm_out,
    output logic any_alarm_avail_out,
    output logic new_alarm_out,
    output logic [rssl_pkg::NUM_RT_ALARMS-1:0] rt_alarm_out,
    // Totalizer sources
    output logic [rssl_pkg::NUM_TOTALIZERS-1:0] run_state_out,
    output logic [rssl_pkg::NUM_TOTALIZERS-1:0] wrap_out,
    output logic [rssl_pkg::NUM_TOTALIZERS-1:0]
        intermediate_count_output_out,
    output logic [rssl_pkg::NUM_TOTALIZERS-1:0] count_pulse_out,
    // Other sources
    output logic [rssl_pkg::NUM_LOGIC_EQ-1:0] logic_eq_out,
    output logic batch_pf_abort_out,
    output logic batch_running_out,
    output logic [rssl_pkg::NUM_HYBRID_DI-1:0] hybrid_di_out,
    output logic media_present_out,
    output logic archive_online_out
);
    import rssl_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Declarations

    // Tick prescaler and tick strobe
    logic [MS_CNT_W-1:0] ms_cnt_ff;
    logic ms_tick_ff;
    localparam logic [MS_CNT_W-1:0] MS_LAST = MS_CNT_W'(MS_TICK_CYCLES_P - 1);

    // Alarm state
    logic [NUM_ALARMS-1:0] alarm_live;
    logic [NUM_ALARMS-1:0] alarm_prev_ff;
    logic [NUM_ALARMS-1:0] alarm_state_ff;
    logic [NUM_ALARMS-1:0] alarm_ack_ff;
    logic [NUM_GROUPS-1:0] nxt_group;
    logic [NUM_GROUPS-1:0] alarm_group_ff;
    logic any_alarm_ff;
    logic any_avail_ff;
    logic new_alarm_ff;
    logic nxt_new_alarm;
    logic [NUM_RT_ALARMS-1:0] rt_alarm_ff;

    // Totalizer outputs
    logic [NUM_TOTALIZERS-1:0] tot_avail;
    logic [NUM_TOTALIZERS-1:0] run_state_ff;
    logic [NUM_TOTALIZERS-1:0] wrap_ff;
    logic [NUM_TOTALIZERS-1:0] inter_ff;
    logic [NUM_TOTALIZERS-1:0] count_ff;

    // Miscellaneous sources
    logic [NUM_LOGIC_EQ-1:0] logic_eq_ff;
    logic batch_running_ff;
    logic [NUM_HYBRID_DI-1:0] hybrid_di_ff;
    logic [NUM_HYBRID_DI-1:0] hybrid_avail;
    logic media_present_ff;
    logic archive_online_ff;

    // Power-up abort sequencer
    rssl_pu_state_type pu_state_ff;
    logic pf_abort_ff;

    // Interrupt and register state
    logic [IRQ_W-1:0] irq_status_ff;
    logic [IRQ_W-1:0] irq_enable_ff;
    logic [IRQ_W-1:0] irq_event;
    logic [IRQ_W-1:0] irq_clear;
    logic irq_ff;
    logic [DATA_W-1:0] rdata_ff;
    logic [DATA_W-1:0] nxt_rdata;

    ////////////////////////////////////////////////////////////////////////
    // Functions

    // Next value of a retriggerable tick-timed pulse counter
    function automatic logic [PULSE_CNT_W-1:0] pulse_next(
        input logic [PULSE_CNT_W-1:0] cnt,
        input logic trig,
        input logic tick,
        input logic [PULSE_CNT_W-1:0] load
    );
        logic [PULSE_CNT_W-1:0] res;
        res = cnt;
        if (trig) begin
            // Retrigger reloads full length
            res = load;
        end else if (tick && (cnt != PULSE_ZERO)) begin
            // Count down one millisecond
            res = cnt - PULSE_ONE;
        end
        return res;
    endfunction : pulse_next

    ////////////////////////////////////////////////////////////////////////
    // Millisecond tick

    // Free-running prescaler, one-cycle tick each millisecond
    // prescaled tick
    always_ff @(posedge sys_clk_in) begin
        if (!reset_n_in) begin
            ms_cnt_ff <= '0;
            ms_tick_ff <= 1'b0;
        end else if (ms_cnt_ff == MS_LAST) begin
            ms_cnt_ff <= '0;
            ms_tick_ff <= 1'b1;
        end else begin
            ms_cnt_ff <= ms_cnt_ff + 16'h0001;
            ms_tick_ff <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Alarm sources

    // Only enabled alarms count as live
    // enable gating
    assign alarm_live = alarm_active_in & alarm_enable_in;

    // Group reduction over assigned alarms, code 0 means no group
    always_comb begin
        nxt_group = '0;
        for (int a = 0; a < NUM_ALARMS; a++) begin
            for (int g = 0; g < NUM_GROUPS; g++) begin
                if (alarm_live[a] &&
                    (alarm_group_sel_in[a*GROUP_SEL_W +: GROUP_SEL_W] ==
                     GROUP_SEL_W'(g + 1))) begin
                    nxt_group[g] = 1'b1;
                end
            end
        end
    end

    // Any alarm went from inactive to active
    // rising edge
    assign nxt_new_alarm = |(alarm_live & ~alarm_prev_ff);

    // Alarm active and acknowledge flags
    always_ff @(posedge sys_clk_in) begin
        if (!reset_n_in) begin
            alarm_state_ff <= '0;
            alarm_ack_ff <= '0;
            alarm_prev_ff <= '0;
        end else begin
            alarm_state_ff <= alarm_live;
            alarm_ack_ff <= alarm_unack_in & alarm_ack_type_in &
                            alarm_enable_in;
            alarm_prev_ff <= alarm_live;
        end
    end

    // Group, any-alarm and new-alarm flags
    always_ff @(posedge sys_clk_in) begin
        if (!reset_n_in) begin
            alarm_group_ff <= '0;
            any_alarm_ff <= 1'b0;
            any_avail_ff <= 1'b0;
            new_alarm_ff <= 1'b0;
        end else begin
            alarm_group_ff <= nxt_group;
            any_alarm_ff <= |alarm_live;
            any_avail_ff <= |alarm_enable_in;
            new_alarm_ff <= nxt_new_alarm;
        end
    end

    // Real-time alarm flags
    always_ff @(posedge sys_clk_in) begin
        if (!reset_n_in) begin
            rt_alarm_ff <= '0;
        end else begin
            rt_alarm_ff <= rt_alarm_active_in & rt_alarm_enable_in;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Totalizer sources

    // A totalizer source exists only with option and enable
    assign tot_avail = {NUM_TOTALIZERS{tot_option_in}} & tot_enable_in;

    // Run state follows counting activity
    always_ff @(posedge sys_clk_in) begin
        if (!reset_n_in) begin
            run_state_ff <= '0;
        end else begin
            run_state_ff <= tot_running_in & tot_avail;
        end
    end

    // One set of timers per totalizer
    for (genvar t = 0; t < NUM_TOTALIZERS; t++) begin : g_tot
        logic [PULSE_CNT_W-1:0] wrap_cnt_ff;
        logic [PULSE_CNT_W-1:0] inter_cnt_ff;
        logic [PULSE_CNT_W-1:0] count_cnt_ff;
        logic [PULSE_CNT_W-1:0] nxt_wrap_cnt;
        logic [PULSE_CNT_W-1:0] nxt_inter_cnt;
        logic [PULSE_CNT_W-1:0] nxt_count_cnt;
        logic wrap_latch_ff;
        logic nxt_wrap_latch;

        assign nxt_wrap_cnt = !tot_avail[t] ? PULSE_ZERO :
            pulse_next(wrap_cnt_ff,
                       tot_wrap_reached_in[t] && tot_wrap_auto_in[t],
                       ms_tick_ff, WRAP_PULSE_TICKS);
        assign nxt_inter_cnt = !tot_avail[t] ? PULSE_ZERO :
            pulse_next(inter_cnt_ff, tot_inter_reached_in[t],
                       ms_tick_ff, INTER_PULSE_TICKS);
        assign nxt_count_cnt = !tot_avail[t] ? PULSE_ZERO :
            pulse_next(count_cnt_ff, tot_whole_count_in[t],
                       ms_tick_ff, COUNT_PULSE_TICKS);

        // Manual wrap latch, a new wrap wins over a reset
        always_comb begin
            nxt_wrap_latch = wrap_latch_ff;
            if (!tot_avail[t] || tot_wrap_auto_in[t]) begin
                // Latch unused in auto mode
                nxt_wrap_latch = 1'b0;
            end else if (tot_wrap_reached_in[t]) begin
                nxt_wrap_latch = 1'b1;
            end else if (tot_reset_in[t]) begin
                nxt_wrap_latch = 1'b0;
            end
        end

        // Timer counters and latch
        always_ff @(posedge sys_clk_in) begin
            if (!reset_n_in) begin
                wrap_cnt_ff <= PULSE_ZERO;
                inter_cnt_ff <= PULSE_ZERO;
                count_cnt_ff <= PULSE_ZERO;
                wrap_latch_ff <= 1'b0;
            end else begin
                wrap_cnt_ff <= nxt_wrap_cnt;
                inter_cnt_ff <= nxt_inter_cnt;
                count_cnt_ff <= nxt_count_cnt;
                wrap_latch_ff <= nxt_wrap_latch;
            end
        end

        // Registered pulse outputs, aligned with counter state
        always_ff @(posedge sys_clk_in) begin
            if (!reset_n_in) begin
                wrap_ff[t] <= 1'b0;
                inter_ff[t] <= 1'b0;
                count_ff[t] <= 1'b0;
            end else begin
                wrap_ff[t] <= (nxt_wrap_cnt != PULSE_ZERO) || nxt_wrap_latch;
                inter_ff[t] <= nxt_inter_cnt != PULSE_ZERO;
                count_ff[t] <= nxt_count_cnt != PULSE_ZERO;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Logic, batch, hybrid and archive sources

    // Hybrid inputs C1..C5 from module C, D1..D5 from module D
    for (genvar h = 0; h < NUM_HYBRID_DI; h++) begin : g_hyb
        assign hybrid_avail[h] = hybrid_fitted_in[h / HYBRID_DI_PER_MOD];
    end

    // Registered status flags, only logic and hybrid ones gated
    always_ff @(posedge sys_clk_in) begin
        if (!reset_n_in) begin
            logic_eq_ff <= '0;
            batch_running_ff <= 1'b0;
            hybrid_di_ff <= '0;
            media_present_ff <= 1'b0;
            archive_online_ff <= 1'b0;
        end else begin
            logic_eq_ff <= logic_eq_result_in & logic_eq_enable_in &
                           {NUM_LOGIC_EQ{math_option_in}};
            batch_running_ff <= batch_running_in;
            hybrid_di_ff <= hybrid_di_in & hybrid_avail;
            media_present_ff <= media_detect_in;
            archive_online_ff <= archive_active_in;
        end
    end

    // One-shot abort pulse after reset release
    always_ff @(posedge sys_clk_in) begin
        if (!reset_n_in) begin
            pu_state_ff <= PU_WAIT;
            pf_abort_ff <= 1'b0;
        end else begin
            case (pu_state_ff)
                // First edge after release raises the pulse
                PU_WAIT: begin
                    pu_state_ff <= PU_PULSE;
                    pf_abort_ff <= 1'b1;
                end
                // Pulse lasts one cycle
                PU_PULSE: begin
                    pu_state_ff <= PU_DONE;
                    pf_abort_ff <= 1'b0;
                end
                // Stays quiet until next reset
                PU_DONE: begin
                    pu_state_ff <= PU_DONE;
                    pf_abort_ff <= 1'b0;
                end
                default: begin
                    pu_state_ff <= PU_DONE;
                    pf_abort_ff <= 1'b0;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Interrupts

    // Event sources, new-alarm, media and abort as one-cycle pulses, wrap and inter follow their inputs
    always_comb begin
        irq_event = '0;
        irq_event[IRQ_NEW_ALARM_BIT] = nxt_new_alarm;
        irq_event[IRQ_WRAP_BIT] = |(tot_wrap_reached_in & tot_avail);
        irq_event[IRQ_INTER_BIT] = |(tot_inter_reached_in & tot_avail);
        irq_event[IRQ_MEDIA_BIT] = media_detect_in & ~media_present_ff;
        irq_event[IRQ_PF_ABORT_BIT] = pu_state_ff == PU_WAIT;
    end

    // Write-one-to-clear strobe bits
    assign irq_clear = (reg_wr_in && (reg_addr_in == IRQ_CLEAR_OFS)) ?
                       reg_wdata_in[IRQ_W-1:0] : IRQ_RESET_VAL;

    // Sticky status, a new event wins over a clear
    always_ff @(posedge sys_clk_in) begin
        if (!reset_n_in) begin
            irq_status_ff <= IRQ_RESET_VAL;
        end else begin
            irq_status_ff <= (irq_status_ff & ~irq_clear) | irq_event;
        end
    end

    // Enable register
    always_ff @(posedge sys_clk_in) begin
        if (!reset_n_in) begin
            irq_enable_ff <= IRQ_RESET_VAL;
        end else if (reg_wr_in && (reg_addr_in == IRQ_ENABLE_OFS)) begin
            irq_enable_ff <= reg_wdata_in[IRQ_W-1:0];
        end
    end

    // Level interrupt from enabled status bits
    always_ff @(posedge sys_clk_in) begin
        if (!reset_n_in) begin
            irq_ff <= 1'b0;
        end else begin
            irq_ff <= |(irq_status_ff & irq_enable_ff);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Register read

    // Read mux, unmapped and write-only addresses read zero
    always_comb begin
        nxt_rdata = DATA_ZERO;
        case (reg_addr_in)
            IRQ_STATUS_OFS: begin
                nxt_rdata[IRQ_W-1:0] = irq_status_ff;
            end
            IRQ_ENABLE_OFS: begin
                nxt_rdata[IRQ_W-1:0] = irq_enable_ff;
            end
            SUMMARY_OFS: begin
                nxt_rdata = {16'h0000, media_present_ff, archive_online_ff,
                             batch_running_ff, any_alarm_ff,
                             alarm_group_ff};
            end
            default: begin
                nxt_rdata = DATA_ZERO;
            end
        endcase
    end

    // Read data valid only in the cycle after the strobe
    always_ff @(posedge sys_clk_in) begin
        if (!reset_n_in) begin
            rdata_ff <= DATA_ZERO;
        end else if (reg_rd_in) begin
            rdata_ff <= nxt_rdata;
        end else begin
            rdata_ff <= DATA_ZERO;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Output drive

    assign reg_rdata_out = rdata_ff;
    assign irq_out = irq_ff;
    assign alarm_state_out = alarm_state_ff;
    assign alarm_ack_out = alarm_ack_ff;
    assign alarm_group_out = alarm_group_ff;
    assign any_alarm_out = any_alarm_ff;
    assign any_alarm_avail_out = any_avail_ff;
    assign new_alarm_out = new_alarm_ff;
    assign rt_alarm_out = rt_alarm_ff;
    assign run_state_out = run_state_ff;
    assign wrap_out = wrap_ff;
    assign intermediate_count_output_out = inter_ff;
    assign count_pulse_out = count_ff;
    assign logic_eq_out = logic_eq_ff;
    assign batch_pf_abort_out = pf_abort_ff;
    assign batch_running_out = batch_running_ff;
    assign hybrid_di_out = hybrid_di_ff;
    assign media_present_out = media_present_ff;
    assign archive_online_out = archive_online_ff;

endmodule : rssl_top

//--- sim/rssl_props.sv
// Checker of the alarm, logic and power-up sources
`timescale 1ns/1ps
module rssl_props import rssl_pkg::*; (
    // Clock and reset
    input wire logic sys_clk_in,
    input wire logic reset_n_in,
    // Alarm side
    input wire logic [NUM_ALARMS-1:0] alarm_enable_in,
    input wire logic [NUM_ALARMS-1:0] alarm_active_in,
    input wire logic [NUM_ALARMS-1:0] alarm_state_out,
    input wire logic any_alarm_out,
    input wire logic any_alarm_avail_out,
    input wire logic new_alarm_out,
    // Logic results and batch
    input wire logic math_option_in,
    input wire logic [NUM_LOGIC_EQ-1:0] logic_eq_enable_in,
    input wire logic [NUM_LOGIC_EQ-1:0] logic_eq_result_in,
    input wire logic [NUM_LOGIC_EQ-1:0] logic_eq_out,
    input wire logic batch_pf_abort_out
);
    // Alarms that are both enabled and active
    wire logic [NUM_ALARMS-1:0] live = alarm_active_in & alarm_enable_in;
    default clocking cb @(posedge sys_clk_in);
    endclocking
    default disable iff (!reset_n_in);
    ////////////////////////////////////////////////////////////////////////
    chk_alarm_state: assert property ($past(reset_n_in) |->
        alarm_state_out == $past(live)) else $error("alarm state wrong");
    chk_any_alarm: assert property ($past(reset_n_in) |->
        any_alarm_out == $past(|live)) else $error("any alarm wrong");
    chk_alarm_avail: assert property ($past(reset_n_in) |->
        any_alarm_avail_out == $past(|alarm_enable_in))
        else $error("availability wrong");
    chk_new_alarm: assert property ($past(reset_n_in, 2) |->
        new_alarm_out == |($past(live) & ~$past(live, 2)))
        else $error("new alarm wrong");
    chk_logic_result: assert property ($past(reset_n_in) |->
        logic_eq_out == $past(logic_eq_result_in & logic_eq_enable_in
        & {NUM_LOGIC_EQ{math_option_in}})) else $error("logic wrong");
    chk_logic_gated: assert property (!math_option_in |=>
        logic_eq_out == '0) else $error("logic not gated");
    chk_abort_after_reset: assert property ($rose(reset_n_in) |->
        ##[0:2] batch_pf_abort_out) else $error("no abort pulse");
    chk_abort_single: assert property (batch_pf_abort_out |=>
        !batch_pf_abort_out [*8]) else $error("abort pulse repeated");
    // Main scenarios
    cov_new_alarm: cover property (new_alarm_out);
    cov_any_alarm: cover property (any_alarm_out);
    cov_logic_out: cover property (logic_eq_out != '0);
endmodule : rssl_props
bind rssl_top rssl_props u_props (.*);

//--- sim/tb_rssl_top.sv
// Self-checking bench of the recorder signal source logic
`timescale 1ns/1ps
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin errors++; \
    $display("MISMATCH %s exp %0h got %0h", n, e, g); end end
module tb_rssl_top;
    import rssl_pkg::*;
    ////////////////////////////////////////////////////////////////////////
    // Stimulus and observed signals
    logic sys_clk_in = 1'b0, reset_n_in = 1'b0, reg_wr_in = 1'b0;
    logic reg_rd_in = 1'b0, tot_option_in = 1'b0, math_option_in = 1'b0;
    logic batch_running_in = 1'b0, media_detect_in = 1'b0;
    logic archive_active_in = 1'b0;
    logic [ADDR_W-1:0] reg_addr_in = 8'h00;
    logic [DATA_W-1:0] reg_wdata_in = 32'h00000000, reg_rdata_out;
    logic [NUM_ALARMS-1:0] alarm_enable_in = '0, alarm_active_in = '0;
    logic [NUM_ALARMS-1:0] alarm_unack_in = '0, alarm_ack_type_in = '0;
    logic [NUM_ALARMS*GROUP_SEL_W-1:0] alarm_group_sel_in = '0;
    logic [NUM_RT_ALARMS-1:0] rt_alarm_enable_in = '0;
    logic [NUM_RT_ALARMS-1:0] rt_alarm_active_in = '0, rt_alarm_out;
    logic [NUM_TOTALIZERS-1:0] tot_enable_in = '0, tot_running_in = '0;
    logic [NUM_TOTALIZERS-1:0] tot_wrap_auto_in = '0, tot_reset_in = '0;
    logic [NUM_TOTALIZERS-1:0] tot_wrap_reached_in = '0;
    logic [NUM_TOTALIZERS-1:0] tot_inter_reached_in = '0;
    logic [NUM_TOTALIZERS-1:0] tot_whole_count_in = '0;
    logic [NUM_LOGIC_EQ-1:0] logic_eq_enable_in = '0;
    logic [NUM_LOGIC_EQ-1:0] logic_eq_result_in = '0, logic_eq_out;
    logic [NUM_HYBRID_MOD-1:0] hybrid_fitted_in = '0;
    logic [NUM_HYBRID_DI-1:0] hybrid_di_in = '0, hybrid_di_out;
    logic [NUM_ALARMS-1:0] alarm_state_out, alarm_ack_out;
    logic [NUM_GROUPS-1:0] alarm_group_out;
    logic [NUM_TOTALIZERS-1:0] run_state_out, wrap_out, count_pulse_out;
    logic [NUM_TOTALIZERS-1:0] intermediate_count_output_out;
    logic irq_out, any_alarm_out, any_alarm_avail_out, new_alarm_out;
    logic batch_pf_abort_out, batch_running_out, media_present_out;
    logic archive_online_out;
    int errors = 0;
    int checked = 0;
    // Short prescaler so a 1 s pulse is 4000 cycles
    rssl_top #(.MS_TICK_CYCLES_P(4)) dut (.*);
    always #12.5 sys_clk_in = ~sys_clk_in;
    ////////////////////////////////////////////////////////////////////////
    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk_in);
    endtask : cyc
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk_in);
        reg_wr_in <= 1'b1;
        reg_addr_in <= a;
        reg_wdata_in <= d;
        @(posedge sys_clk_in);
        reg_wr_in <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge sys_clk_in);
        reg_rd_in <= 1'b1;
        reg_addr_in <= a;
        @(posedge sys_clk_in);
        reg_rd_in <= 1'b0;
        #1 `CHK("rdata", e, reg_rdata_out)
    endtask : rd
    task automatic stop_test;
        if (errors == 0 && checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : stop_test
    ////////////////////////////////////////////////////////////////////////
    initial begin : watchdog
        #200us;
        errors++;
        stop_test();
    end
    initial begin : main
        cyc(6);
        reset_n_in <= 1'b1;
        rd(IRQ_STATUS_OFS, 32'h00000010);
        wr(IRQ_ENABLE_OFS, 32'h0000001F);
        cyc(2);
        #1 `CHK("irq", 1'b1, irq_out)
        wr(IRQ_CLEAR_OFS, 32'h0000001F);
        rd(8'h40, 32'h00000000);
        rd(IRQ_STATUS_OFS, 32'h00000000);
        `CHK("irq clr", 1'b0, irq_out)
        // Alarm 9 is active but disabled, so group 7 stays low
        @(posedge sys_clk_in);
        alarm_enable_in <= 96'h3F;
        alarm_active_in <= 96'h220;
        alarm_unack_in <= '1;
        alarm_ack_type_in <= 96'h20;
        alarm_group_sel_in[5*4+:4] <= 4'h3;
        alarm_group_sel_in[9*4+:4] <= 4'h7;
        rt_alarm_enable_in <= 4'h5;
        rt_alarm_active_in <= 4'h3;
        math_option_in <= 1'b1;
        logic_eq_enable_in <= 24'h00FF0F;
        logic_eq_result_in <= 24'hF0F0F0;
        hybrid_fitted_in <= 2'h1;
        hybrid_di_in <= 10'h3FF;
        {media_detect_in, archive_active_in, batch_running_in} <= 3'h7;
        cyc(3);
        #1 `CHK("state", 96'h20, alarm_state_out)
        `CHK("ack", 96'h20, alarm_ack_out)
        `CHK("group", 12'h004, alarm_group_out)
        `CHK("rt", 4'h1, rt_alarm_out)
        `CHK("logic", 24'h00F000, logic_eq_out)
        `CHK("hybrid", 10'h01F, hybrid_di_out)
        `CHK("flags", 3'h7, {media_present_out, archive_online_out,
            batch_running_out})
        rd(IRQ_STATUS_OFS, 32'h00000009);
        rd(SUMMARY_OFS, 32'h0000F004);
        `CHK("irq on", 1'b1, irq_out)
        wr(IRQ_ENABLE_OFS, 32'h00000000);
        cyc(2);
        #1 `CHK("irq mask", 1'b0, irq_out)
        wr(IRQ_CLEAR_OFS, 32'h0000001F);
        wr(IRQ_ENABLE_OFS, 32'h0000001F);
        math_option_in <= 1'b0;
        hybrid_fitted_in <= 2'h2;
        tot_option_in <= 1'b1;
        tot_enable_in <= 48'h3;
        tot_wrap_auto_in <= 48'h1;
        tot_running_in <= 48'h6;
        @(posedge sys_clk_in);
        tot_whole_count_in <= 48'h1;
        tot_wrap_reached_in <= 48'h3;
        tot_inter_reached_in <= 48'h1;
        @(posedge sys_clk_in);
        tot_whole_count_in <= '0;
        tot_wrap_reached_in <= '0;
        tot_inter_reached_in <= '0;
        cyc(391);
        #1 `CHK("logic off", 24'h0, logic_eq_out)
        `CHK("hybrid d", 10'h3E0, hybrid_di_out)
        `CHK("run", 48'h2, run_state_out)
        `CHK("count hi", 48'h1, count_pulse_out)
        // Retrigger shortly before the first count pulse would end
        @(posedge sys_clk_in);
        tot_whole_count_in <= 48'h1;
        @(posedge sys_clk_in);
        tot_whole_count_in <= '0;
        cyc(13);
        #1 `CHK("count re", 48'h1, count_pulse_out)
        cyc(400);
        #1 `CHK("count lo", 48'h0, count_pulse_out)
        cyc(3180);
        #1 `CHK("wrap hi", 48'h3, wrap_out)
        `CHK("inter hi", 48'h1, intermediate_count_output_out)
        cyc(30);
        #1 `CHK("wrap lo", 48'h2, wrap_out)
        `CHK("inter lo", 48'h0, intermediate_count_output_out)
        rd(IRQ_STATUS_OFS, 32'h00000006);
        @(posedge sys_clk_in);
        tot_reset_in <= 48'h2;
        @(posedge sys_clk_in);
        tot_reset_in <= '0;
        cyc(2);
        #1 `CHK("wrap rst", 48'h0, wrap_out)
        rd(IRQ_ENABLE_OFS, 32'h0000001F);
        stop_test();
    end
endmodule : tb_rssl_top
